//--- hdl/timer_ctl_pkg.sv
package timer_ctl_pkg;
	// ==========================================
	// Register offsets
	localparam logic [3:0] ADDR_CTL_ONE = 4'h0;
	localparam logic [3:0] ADDR_CTL_TWO = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam logic [3:0] ADDR_MASK = 4'h3;
	localparam logic [3:0] ADDR_CMP_A_HI = 4'h4;
	localparam logic [3:0] ADDR_CMP_A_LO = 4'h5;
	localparam logic [3:0] ADDR_CMP_B_HI = 4'h6;
	localparam logic [3:0] ADDR_CMP_B_LO = 4'h7;
	localparam logic [3:0] ADDR_CNT_HI = 4'h8;
	localparam logic [3:0] ADDR_CNT_LO = 4'h9;
	localparam logic [3:0] ADDR_CAP_A_HI = 4'hA;
	localparam logic [3:0] ADDR_CAP_A_LO = 4'hB;
	localparam logic [3:0] ADDR_CAP_B_HI = 4'hC;
	localparam logic [3:0] ADDR_CAP_B_LO = 4'hD;
	// ==========================================
	// Reset values and counter maximum
	localparam logic [7:0] CTL_ONE_RST = 8'h00;
	localparam logic [7:0] CTL_TWO_RST = 8'h00;
	localparam logic [15:0] CMP_A_RST = 16'h8000;
	localparam logic [15:0] CMP_B_RST = 16'h8000;
	localparam logic [15:0] CNT_RST = 16'hFFFC;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	// ==========================================
	// Prescaler divide counts
	localparam logic [2:0] DIV2_MAX = 3'h1;
	localparam logic [2:0] DIV4_MAX = 3'h3;
	localparam logic [2:0] DIV8_MAX = 3'h7;
	// ==========================================
	// Status bit positions (event flags)
	localparam int ST_CAP_A = 0;
	localparam int ST_CAP_B = 1;
	localparam int ST_CMP_A = 2;
	localparam int ST_CMP_B = 3;
	localparam int ST_OVF = 4;
	// ==========================================
	// Control fields
	typedef struct packed {
		logic capture_irq_enable;
		logic compare_irq_enable;
		logic overflow_irq_enable;
		logic force_compare_b;
		logic force_compare_a;
		logic level_b;
		logic capture_a_edge;
		logic level_a;
	} ctl_one_s;
	typedef struct packed {
		logic compare_a_pin_enable;
		logic compare_b_pin_enable;
		logic single_pulse_mode;
		logic pwm_mode;
		logic [1:0] clock_select;
		logic capture_b_edge;
		logic ext_clock_edge;
	} ctl_two_s;
	typedef enum logic [1:0] {
		CLK_DIV4 = 2'h0,
		CLK_DIV2 = 2'h1,
		CLK_DIV8 = 2'h2,
		CLK_EXT = 2'h3
	} clk_sel_e;
	// Pulse generator states
	typedef enum logic [2:0] {
		PG_IDLE = 3'b001,
		PG_ACTIVE = 3'b010,
		PG_DONE = 3'b100
	} pulse_e;
	// Register bus request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_s;
	// Pins sampled
	typedef struct packed {
		logic capture_pin_a;
		logic capture_pin_b;
		logic ext_clock_pin;
	} pins_in_s;
	// Pin outputs with enables
	typedef struct packed {
		logic compare_pin_a;
		logic compare_pin_a_oe;
		logic compare_pin_b;
		logic compare_pin_b_oe;
	} pins_out_s;
endpackage : timer_ctl_pkg

//--- hdl/timer16_ctl.sv
module timer16_ctl #(
	parameter bit HAS_EXT_CLOCK = 1'b1
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// Register port
	input wire timer_ctl_pkg::bus_req_s bus_in,
	output logic [7:0] rdata_out,
	// Pins
	input wire timer_ctl_pkg::pins_in_s pins_in,
	output timer_ctl_pkg::pins_out_s pins_out,
	// Interrupt
	output logic irq_out
);
	import timer_ctl_pkg::*;

	// ==========================================
	// State
	typedef struct packed {
		ctl_one_s c1;
		ctl_two_s c2;
		logic [4:0] status;
		logic [4:0] mask;
		logic [15:0] cmp_a;
		logic [15:0] cmp_b;
		logic [15:0] cnt;
		logic [15:0] cap_a;
		logic [15:0] cap_b;
		logic [2:0] presc;
		logic [2:0] pins_prev;
		logic out_a;
		logic out_b;
		pulse_e pg;
		logic [7:0] rdata;
		pins_out_s po;
		logic irq;
	} state_s;

	state_s s_q;
	state_s s_d;

	// Edge match helper: rising when sel is 1, falling when 0
	function automatic logic edge_hit(input logic sel, input logic prev,
		input logic cur);
		edge_hit = sel ? (!prev && cur) : (prev && !cur);
	endfunction : edge_hit

	logic tick;
	logic hit_a;
	logic hit_b;
	logic cap_a_ev;
	logic cap_b_ev;
	logic ovf_ev;
	logic [4:0] ev;
	logic [2:0] div_max;
	logic [15:0] cnt_next;

	// ==========================================
	// Next state
	always_comb begin
		s_d = s_q;
		tick = 1'b0;
		div_max = DIV4_MAX;
		s_d.pins_prev = {pins_in.capture_pin_a, pins_in.capture_pin_b,
			pins_in.ext_clock_pin};
		// Counter clock choice
		case (clk_sel_e'(s_q.c2.clock_select))
			CLK_DIV4: div_max = DIV4_MAX;
			CLK_DIV2: div_max = DIV2_MAX;
			CLK_DIV8: div_max = DIV8_MAX;
			default: div_max = DIV8_MAX;
		endcase
		if (s_q.c2.clock_select == CLK_EXT) begin
			// Absent pin leaves the counter frozen
			tick = HAS_EXT_CLOCK && edge_hit(s_q.c2.ext_clock_edge,
				s_q.pins_prev[0], pins_in.ext_clock_pin);
			s_d.presc = 3'h0;
		end else if (s_q.presc >= div_max) begin
			tick = 1'b1;
			s_d.presc = 3'h0;
		end else begin
			s_d.presc = s_q.presc + 3'h1;
		end
		cnt_next = s_q.cnt + 16'h0001;
		hit_a = tick && (cnt_next == s_q.cmp_a);
		hit_b = tick && (cnt_next == s_q.cmp_b);
		ovf_ev = tick && (s_q.cnt == CNT_MAX);
		cap_a_ev = edge_hit(s_q.c1.capture_a_edge, s_q.pins_prev[2],
			pins_in.capture_pin_a);
		cap_b_ev = edge_hit(s_q.c2.capture_b_edge, s_q.pins_prev[1],
			pins_in.capture_pin_b);
		if (tick) begin
			s_d.cnt = cnt_next;
		end
		if (cap_a_ev) begin
			s_d.cap_a = s_q.cnt;
		end
		if (cap_b_ev) begin
			s_d.cap_b = s_q.cnt;
		end
		// Waveform on pin a
		if (s_q.c2.pwm_mode) begin
			// Period restarts the counter; compare a ends the pulse
			if (hit_b) begin
				s_d.cnt = 16'h0000;
				s_d.out_a = s_q.c1.level_b;
			end else if (hit_a) begin
				s_d.out_a = s_q.c1.level_a;
			end
		end else if (s_q.c2.single_pulse_mode) begin
			case (s_q.pg)
				PG_IDLE: begin
					if (cap_a_ev) begin
						s_d.cnt = 16'h0000;
						s_d.out_a = s_q.c1.level_b;
						s_d.pg = PG_ACTIVE;
					end
				end
				PG_ACTIVE: begin
					if (hit_a) begin
						s_d.out_a = s_q.c1.level_a;
						s_d.pg = PG_IDLE;
					end
				end
				default: s_d.pg = PG_IDLE;
			endcase
		end else begin
			s_d.pg = PG_IDLE;
			if (s_q.c1.force_compare_a || hit_a) begin
				s_d.out_a = s_q.c1.level_a;
			end
		end
		// Pin b follows force b and compare b in every mode
		if (s_q.c1.force_compare_b || hit_b) begin
			s_d.out_b = s_q.c1.level_b;
		end
		// Pins handed out only when enabled; compare keeps running
		s_d.po.compare_pin_a = s_d.out_a;
		s_d.po.compare_pin_a_oe = s_q.c2.compare_a_pin_enable;
		s_d.po.compare_pin_b = s_d.out_b;
		s_d.po.compare_pin_b_oe = s_q.c2.compare_b_pin_enable;
		// Events; in modulation mode the period match counts as capture a
		ev = '0;
		ev[ST_CAP_A] = cap_a_ev || (s_q.c2.pwm_mode && hit_b);
		ev[ST_CAP_B] = cap_b_ev;
		ev[ST_CMP_A] = hit_a;
		ev[ST_CMP_B] = hit_b;
		ev[ST_OVF] = ovf_ev;
		// Read data and read-clear, a set in the same cycle wins
		s_d.rdata = 8'h00;
		if (bus_in.rd) begin
			case (bus_in.addr)
				ADDR_CTL_ONE: s_d.rdata = s_q.c1;
				ADDR_CTL_TWO: s_d.rdata = s_q.c2;
				ADDR_STATUS: begin
					s_d.rdata = {3'h0, s_q.status};
					s_d.status = 5'h00;
				end
				ADDR_MASK: s_d.rdata = {3'h0, s_q.mask};
				ADDR_CMP_A_HI: s_d.rdata = s_q.cmp_a[15:8];
				ADDR_CMP_A_LO: s_d.rdata = s_q.cmp_a[7:0];
				ADDR_CMP_B_HI: s_d.rdata = s_q.cmp_b[15:8];
				ADDR_CMP_B_LO: s_d.rdata = s_q.cmp_b[7:0];
				ADDR_CNT_HI: s_d.rdata = s_q.cnt[15:8];
				ADDR_CNT_LO: s_d.rdata = s_q.cnt[7:0];
				ADDR_CAP_A_HI: s_d.rdata = s_q.cap_a[15:8];
				ADDR_CAP_A_LO: s_d.rdata = s_q.cap_a[7:0];
				ADDR_CAP_B_HI: s_d.rdata = s_q.cap_b[15:8];
				ADDR_CAP_B_LO: s_d.rdata = s_q.cap_b[7:0];
				default: s_d.rdata = 8'h00;
			endcase
		end
		s_d.status = s_d.status | ev;
		// Register writes
		if (bus_in.wr) begin
			case (bus_in.addr)
				ADDR_CTL_ONE: s_d.c1 = bus_in.wdata;
				ADDR_CTL_TWO: s_d.c2 = bus_in.wdata;
				ADDR_MASK: s_d.mask = bus_in.wdata[4:0];
				ADDR_CMP_A_HI: s_d.cmp_a[15:8] = bus_in.wdata;
				ADDR_CMP_A_LO: s_d.cmp_a[7:0] = bus_in.wdata;
				ADDR_CMP_B_HI: s_d.cmp_b[15:8] = bus_in.wdata;
				ADDR_CMP_B_LO: s_d.cmp_b[7:0] = bus_in.wdata;
				ADDR_CNT_LO: s_d.cnt = CNT_RST;
				default: s_d.mask = s_d.mask;
			endcase
		end
		// Interrupt: enables in control one, then the mask
		s_d.irq = |(s_d.status & s_d.mask & {
			s_d.c1.overflow_irq_enable,
			s_d.c1.compare_irq_enable, s_d.c1.compare_irq_enable,
			s_d.c1.capture_irq_enable, s_d.c1.capture_irq_enable});
	end

	// ==========================================
	// State register
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			s_q <= '0;
			s_q.c1 <= CTL_ONE_RST;
			s_q.c2 <= CTL_TWO_RST;
			s_q.cmp_a <= CMP_A_RST;
			s_q.cmp_b <= CMP_B_RST;
			s_q.cnt <= CNT_RST;
			s_q.pg <= PG_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata_out = s_q.rdata;
	assign pins_out = s_q.po;
	assign irq_out = s_q.irq;

	// ==========================================
	// Checks
	property p_ovf_irq;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(ovf_ev && s_q.c1.overflow_irq_enable && s_q.mask[ST_OVF] && !bus_in.wr)
		|=> irq_out;
	endproperty
	a_ovf_irq: assert property (p_ovf_irq) else $error("ovf irq");
	property p_force_b;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		s_q.c1.force_compare_b |=> pins_out.compare_pin_b == $past(s_q.c1.level_b);
	endproperty
	a_force_b: assert property (p_force_b) else $error("force b");
	property p_force_a;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(s_q.c1.force_compare_a && !s_q.c2.pwm_mode && !s_q.c2.single_pulse_mode)
		|=> pins_out.compare_pin_a == $past(s_q.c1.level_a);
	endproperty
	a_force_a: assert property (p_force_a) else $error("force a");
	property p_oe_a;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		1'b1 |=> pins_out.compare_pin_a_oe == $past(s_q.c2.compare_a_pin_enable);
	endproperty
	a_oe_a: assert property (p_oe_a) else $error("oe a");
	property p_oe_b;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		1'b1 |=> pins_out.compare_pin_b_oe == $past(s_q.c2.compare_b_pin_enable);
	endproperty
	a_oe_b: assert property (p_oe_b) else $error("oe b");
	property p_halt;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(!HAS_EXT_CLOCK && s_q.c2.clock_select == CLK_EXT && !bus_in.wr
			&& !s_q.c2.pwm_mode && !s_q.c2.single_pulse_mode) |=> $stable(s_q.cnt);
	endproperty
	a_halt: assert property (p_halt) else $error("halt");
	property p_div4;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(tick && s_q.c2.clock_select == CLK_DIV4 && !bus_in.wr) [*2]
		|-> 1'b0;
	endproperty
	a_div4: assert property (p_div4) else $error("div4");
	property p_ovf;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(ovf_ev && !s_q.c2.pwm_mode) |=> s_q.status[ST_OVF] && s_q.cnt == 16'h0000;
	endproperty
	a_ovf: assert property (p_ovf) else $error("ovf flag");

	// ==========================================
	// Compare matches copy the stored levels
	property p_cmp_b;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		hit_b |=> pins_out.compare_pin_b == $past(s_q.c1.level_b);
	endproperty
	a_cmp_b: assert property (p_cmp_b) else $error("cmp b");
	property p_cmp_a;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(hit_a && !s_q.c2.pwm_mode && !s_q.c2.single_pulse_mode)
		|=> pins_out.compare_pin_a == $past(s_q.c1.level_a);
	endproperty
	a_cmp_a: assert property (p_cmp_a) else $error("cmp a");

	// ==========================================
	// Modulation: period restarts, width ends the pulse
	property p_pwm_period;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(s_q.c2.pwm_mode && hit_b && !bus_in.wr) |=> s_q.cnt == 16'h0000;
	endproperty
	a_pwm_period: assert property (p_pwm_period) else $error("period");
	property p_pwm_level;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(s_q.c2.pwm_mode && hit_b)
		|=> pins_out.compare_pin_a == $past(s_q.c1.level_b);
	endproperty
	a_pwm_level: assert property (p_pwm_level) else $error("pwm lvl");
	property p_pwm_width;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(s_q.c2.pwm_mode && hit_a && !hit_b)
		|=> pins_out.compare_pin_a == $past(s_q.c1.level_a);
	endproperty
	a_pwm_width: assert property (p_pwm_width) else $error("width");
	property p_pwm_flag;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(s_q.c2.pwm_mode && hit_b) |=> s_q.status[ST_CAP_A];
	endproperty
	a_pwm_flag: assert property (p_pwm_flag) else $error("pwm flag");

	// ==========================================
	// Single pulse: start on capture a, end on compare a
	property p_pulse_start;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(s_q.c2.single_pulse_mode && !s_q.c2.pwm_mode && !bus_in.wr
			&& s_q.pg == PG_IDLE && cap_a_ev)
		|=> s_q.cnt == 16'h0000 && s_q.pg == PG_ACTIVE
			&& pins_out.compare_pin_a == $past(s_q.c1.level_b);
	endproperty
	a_pulse_start: assert property (p_pulse_start) else $error("start");
	property p_pulse_end;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(s_q.c2.single_pulse_mode && !s_q.c2.pwm_mode
			&& s_q.pg == PG_ACTIVE && hit_a)
		|=> s_q.pg == PG_IDLE
			&& pins_out.compare_pin_a == $past(s_q.c1.level_a);
	endproperty
	a_pulse_end: assert property (p_pulse_end) else $error("end");

	// ==========================================
	// Captures, the capture a interrupt and the compare a interrupt
	property p_cap_a;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		cap_a_ev |=> s_q.status[ST_CAP_A] && s_q.cap_a == $past(s_q.cnt);
	endproperty
	a_cap_a: assert property (p_cap_a) else $error("cap a");
	property p_cap_b;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		cap_b_ev |=> s_q.status[ST_CAP_B] && s_q.cap_b == $past(s_q.cnt);
	endproperty
	a_cap_b: assert property (p_cap_b) else $error("cap b");
	property p_cap_irq;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(cap_a_ev && s_q.c1.capture_irq_enable && s_q.mask[ST_CAP_A]
			&& !bus_in.wr) |=> irq_out;
	endproperty
	a_cap_irq: assert property (p_cap_irq) else $error("cap irq");
	property p_cmp_irq;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(hit_a && s_q.c1.compare_irq_enable && s_q.mask[ST_CMP_A]
			&& !bus_in.wr) |=> irq_out;
	endproperty
	a_cmp_irq: assert property (p_cmp_irq) else $error("cmp irq");

	// ==========================================
	// Prescaler rates; a write may change the choice
	property p_div2;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(tick && s_q.c2.clock_select == CLK_DIV2 && !bus_in.wr)
		##1 !bus_in.wr |=> tick;
	endproperty
	a_div2: assert property (p_div2) else $error("div2");
	property p_div4_run;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(tick && s_q.c2.clock_select == CLK_DIV4 && !bus_in.wr)
		##1 (!bus_in.wr) [*3] |=> tick;
	endproperty
	a_div4_run: assert property (p_div4_run) else $error("div4 run");
	property p_div8;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(tick && s_q.c2.clock_select == CLK_DIV8 && !bus_in.wr)
		##1 (!bus_in.wr) [*7] |=> tick;
	endproperty
	a_div8: assert property (p_div8) else $error("div8");

	// ==========================================
	// External clock: chosen edge counts, other edge not
	property p_ext_edge;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(HAS_EXT_CLOCK && s_q.c2.clock_select == CLK_EXT && !bus_in.wr
			&& !s_q.c2.pwm_mode && !s_q.c2.single_pulse_mode
			&& (s_q.c2.ext_clock_edge ? $rose(pins_in.ext_clock_pin)
			: $fell(pins_in.ext_clock_pin)))
		|=> s_q.cnt == $past(s_q.cnt) + 16'h0001;
	endproperty
	a_ext_edge: assert property (p_ext_edge) else $error("ext edge");
	property p_ext_other;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(s_q.c2.clock_select == CLK_EXT && !bus_in.wr
			&& !s_q.c2.pwm_mode && !s_q.c2.single_pulse_mode
			&& (s_q.c2.ext_clock_edge ? $fell(pins_in.ext_clock_pin)
			: $rose(pins_in.ext_clock_pin)))
		|=> $stable(s_q.cnt);
	endproperty
	a_ext_other: assert property (p_ext_other) else $error("ext other");
endmodule : timer16_ctl

//--- tb/pin_model.sv
module pin_model (
	// Clock
	input wire logic ref_clk_in,
	// Wanted levels: capture a, capture b, external clock
	input wire logic [2:0] level_in,
	// Levels seen by the timer
	output timer_ctl_pkg::pins_in_s pins_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import timer_ctl_pkg::*;
	// ==========================================
	// Pins idle low, move only after an edge
	initial begin
		pins_out = '0;
	end
	always @(posedge ref_clk_in) begin
		pins_out <= pins_in_s'(level_in);
	end
endmodule : pin_model

//--- tb/timer16_control_modes_test.sv
module timer16_control_modes_test;
	timeunit 1ns;
	timeprecision 1ns;
	import timer_ctl_pkg::*;
	logic ref_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	bus_req_s bus = '0;
	logic [7:0] rdata;
	logic [2:0] level = 3'h0;
	pins_in_s pins;
	pins_out_s pout;
	logic irq;
	int failures = 0;
	int samples_checked = 0;
	logic [15:0] notes[$];
	logic rd_seen = 1'b0;
	logic [7:0] rnd;
	// ==========================================
	// Clock, design and pin source
	always #25 ref_clk_in = ~ref_clk_in;
	timer16_ctl i_timer16_ctl (.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in), .bus_in(bus), .rdata_out(rdata),
		.pins_in(pins), .pins_out(pout), .irq_out(irq));
	pin_model i_pin_model (.ref_clk_in(ref_clk_in), .level_in(level),
		.pins_out(pins));
	// ==========================================
	// Compare tasks; a note holds mask then value
	task check_read(input logic [7:0] got, input logic [15:0] note);
		samples_checked++;
		if ((got & note[15:8]) !== (note[7:0] & note[15:8])) begin
			failures++;
			$display("mismatch %0t got %h exp %h", $time, got, note[7:0]);
		end
	endtask : check_read
	task check_pin(input logic [1:0] got, input logic [1:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask : check_pin
	task close_out;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out
	// ==========================================
	// Bus and pin drivers; a gap cycle avoids double assignment
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk_in) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk_in) bus <= '0;
	endtask : wr
	task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge ref_clk_in) bus <= '{a, 8'h00, 1'b0, 1'b1};
		notes.push_back({m, e});
		@(posedge ref_clk_in) bus <= '0;
	endtask : rd
	task pin(input logic [2:0] l);
		@(posedge ref_clk_in) level <= l;
		repeat (5) @(posedge ref_clk_in);
		#1;
	endtask : pin
	task settle;
		repeat (2) @(posedge ref_clk_in);
		#1;
	endtask : settle
	// Read data stands only in the cycle after the strobe
	always @(posedge ref_clk_in) begin
		if (rd_seen) begin
			check_read(rdata, notes.pop_front());
		end
		rd_seen <= bus.rd;
	end
	// Watchdog well beyond the expected run length
	initial begin
		#500000;
		failures++;
		close_out();
	end
	// ==========================================
	// Main sequence
	initial begin
		rnd = $urandom(95873);
		repeat (12) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		rd(ADDR_CTL_TWO, 8'hFF, 8'h00);
		for (int i = 0; i < 4; i++) begin
			rnd = $urandom;
			wr(ADDR_CTL_ONE, rnd);
			rd(ADDR_CTL_ONE, 8'hFF, rnd);
			wr(ADDR_CTL_TWO, ~rnd);
			rd(ADDR_CTL_TWO, 8'hFF, ~rnd);
		end
		// Forced levels with both pins owned by the timer
		wr(ADDR_CTL_TWO, 8'hC0);
		for (int lv = 0; lv < 2; lv++) begin
			wr(ADDR_CTL_ONE, {5'h03, lv[0], 1'b0, lv[0]});
			settle();
			check_pin({pout.compare_pin_a, pout.compare_pin_b}, {2{lv[0]}});
		end
		check_pin({pout.compare_pin_a_oe, pout.compare_pin_b_oe}, 2'h3);
		wr(ADDR_CTL_TWO, 8'h00);
		settle();
		check_pin({pout.compare_pin_a_oe, pout.compare_pin_b_oe}, 2'h0);
		// Capture edges: wrong edge ignored, mask holds irq back
		wr(ADDR_MASK, 8'h03);
		for (int e = 0; e < 2; e++) begin
			wr(ADDR_CTL_ONE, {6'h20, e[0], 1'b0});
			wr(ADDR_CTL_TWO, {6'h00, e[0], 1'b0});
			pin({~e[0], ~e[0], 1'b0});
			rd(ADDR_STATUS, 8'h03, 8'h00);
			pin({e[0], e[0], 1'b0});
			check_pin({1'b0, irq}, 2'h1);
			rd(ADDR_STATUS, 8'h03, 8'h03);
			settle();
			check_pin({1'b0, irq}, 2'h0);
			wr(ADDR_MASK, 8'h00);
			pin({~e[0], ~e[0], 1'b0});
			pin({e[0], e[0], 1'b0});
			check_pin({1'b0, irq}, 2'h0);
			rd(ADDR_STATUS, 8'h03, 8'h03);
			wr(ADDR_MASK, 8'h03);
		end
		// External clock: only the chosen edge counts, then wrap
		wr(ADDR_MASK, 8'h10);
		wr(ADDR_CTL_ONE, 8'h20);
		wr(ADDR_CTL_TWO, 8'h0D);
		wr(ADDR_CNT_LO, 8'h00);
		rd(ADDR_STATUS, 8'h00, 8'h00);
		for (int k = 0; k < 3; k++) begin
			pin(3'h1);
			pin(3'h0);
		end
		rd(ADDR_CNT_LO, 8'hFF, 8'hFF);
		rd(ADDR_CNT_HI, 8'hFF, 8'hFF);
		check_pin({1'b0, irq}, 2'h0);
		pin(3'h1);
		check_pin({1'b0, irq}, 2'h1);
		rd(ADDR_CNT_LO, 8'hFF, 8'h00);
		rd(ADDR_STATUS, 8'h10, 8'h10);
		wr(ADDR_CTL_TWO, 8'h0C);
		pin(3'h0);
		rd(ADDR_CNT_LO, 8'hFF, 8'h01);
		// Compare matches, stepped by the external clock
		wr(ADDR_CTL_TWO, 8'hCD);
		wr(ADDR_CMP_A_HI, 8'hFF);
		wr(ADDR_CMP_A_LO, 8'hFD);
		wr(ADDR_CMP_B_HI, 8'hFF);
		wr(ADDR_CMP_B_LO, 8'hFE);
		wr(ADDR_CTL_ONE, 8'h18);
		settle();
		check_pin({pout.compare_pin_a, pout.compare_pin_b}, 2'h0);
		wr(ADDR_CTL_ONE, 8'h05);
		wr(ADDR_CNT_LO, 8'h00);
		pin(3'h1);
		check_pin({pout.compare_pin_a, pout.compare_pin_b}, 2'h2);
		pin(3'h0);
		pin(3'h1);
		check_pin({pout.compare_pin_a, pout.compare_pin_b}, 2'h3);
		// Modulation: width 2, period 4
		wr(ADDR_CMP_A_HI, 8'h00);
		wr(ADDR_CMP_A_LO, 8'h02);
		wr(ADDR_CMP_B_HI, 8'h00);
		wr(ADDR_CMP_B_LO, 8'h04);
		wr(ADDR_CTL_ONE, 8'h04);
		wr(ADDR_CTL_TWO, 8'h9D);
		wr(ADDR_CNT_LO, 8'h00);
		rd(ADDR_STATUS, 8'h00, 8'h00);
		for (int k = 0; k < 6; k++) begin
			pin(3'h0);
			pin(3'h1);
		end
		check_pin({1'b0, pout.compare_pin_a}, 2'h0);
		for (int k = 0; k < 2; k++) begin
			pin(3'h0);
			pin(3'h1);
		end
		check_pin({1'b0, pout.compare_pin_a}, 2'h1);
		rd(ADDR_CNT_LO, 8'hFF, 8'h00);
		rd(ADDR_STATUS, 8'h01, 8'h01);
		for (int k = 0; k < 2; k++) begin
			pin(3'h0);
			pin(3'h1);
		end
		check_pin({1'b0, pout.compare_pin_a}, 2'h0);
		// Single pulse of length 3 from a capture a rise
		wr(ADDR_CMP_A_LO, 8'h03);
		wr(ADDR_CTL_ONE, 8'h06);
		wr(ADDR_CTL_TWO, 8'hAD);
		pin(3'h5);
		check_pin({1'b0, pout.compare_pin_a}, 2'h1);
		for (int k = 0; k < 2; k++) begin
			pin(3'h4);
			pin(3'h5);
		end
		check_pin({1'b0, pout.compare_pin_a}, 2'h1);
		pin(3'h4);
		pin(3'h5);
		check_pin({1'b0, pout.compare_pin_a}, 2'h0);
		pin(3'h0);
		// Internal rates, watched by the prescaler checks
		wr(ADDR_CTL_TWO, 8'h04);
		repeat (24) @(posedge ref_clk_in);
		wr(ADDR_CTL_TWO, 8'h08);
		repeat (40) @(posedge ref_clk_in);
		rd(ADDR_CTL_TWO, 8'hFF, 8'h08);
		settle();
		close_out();
	end
endmodule : timer16_control_modes_test
